/* core/rxbm_pkg.sv */
package rxbm_pkg;
   // register byte offsets on the apb slave
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_CFG = 8'h04;
   localparam logic [7:0] REG_QPTR = 8'h08;
   localparam logic [7:0] REG_STAT = 8'h0C;
   // control, configuration and status bit positions
   localparam int CTRL_RXEN_BIT = 0;
   localparam int CFG_JUMBO_BIT = 3;
   localparam int CFG_OFS_LO = 14;
   localparam int CFG_NOFCS_BIT = 17;
   localparam int STAT_BNA_BIT = 0;
   localparam int STAT_RCV_BIT = 1;
   localparam logic [31:0] CFG_MASK = 32'h0002C008;
   // descriptor layout
   localparam int D0_OWN_BIT = 0;
   localparam int D0_WRAP_BIT = 1;
   localparam logic [31:0] DESC_STAT_OFS = 32'h00000004;
   localparam logic [9:0] DESC_LAST_IDX = 10'h3FF;
   localparam logic [6:0] BUF_LAST_POS = 7'h7F;
   // receive status word bit positions
   localparam int ST_BCAST = 31;
   localparam int ST_MHASH = 30;
   localparam int ST_UHASH = 29;
   localparam int ST_EXT = 28;
   localparam int ST_SA_LO = 23;
   localparam int ST_TYPE = 22;
   localparam int ST_VLAN = 21;
   localparam int ST_PRIO = 20;
   localparam int ST_VPRI_LO = 17;
   localparam int ST_CFI = 16;
   localparam int ST_EOF = 15;
   localparam int ST_SOF = 14;
   localparam int ST_OFS_LO = 12;
   localparam int ST_LEN_W = 12;
   localparam logic [15:0] VLAN_TPID = 16'h8100;

   // one received byte from the receive path
   typedef struct packed {
      logic [7:0] data;
      logic last;
      logic err;
      logic fcs;
   } rxbm_beat_t;

   // per-frame address check and tag results, valid with the last beat
   typedef struct packed {
      logic bcast;
      logic mhash;
      logic uhash;
      logic ext;
      logic [3:0] sa_hit;
      logic type_hit;
      logic [15:0] type_id;
      logic [11:0] vlan_id;
      logic [2:0] vlan_pri;
      logic cfi;
   } rxbm_fstat_t;

   // one word request towards system memory
   typedef struct packed {
      logic valid;
      logic write;
      logic [31:0] addr;
      logic [31:0] wdata;
   } rxbm_mreq_t;
endpackage : rxbm_pkg

/* core/rxbm_status_fmt.sv */
`timescale 1ns/1ps
`default_nettype none
module rxbm_status_fmt (
   input wire rxbm_pkg::rxbm_fstat_t fstat,
   input wire logic sof,
   input wire logic eof,
   input wire logic [1:0] ofs,
   input wire logic jumbo,
   input wire logic [13:0] len,
   output logic [31:0] word
);
   logic vlan;

   assign vlan = (fstat.type_id == rxbm_pkg::VLAN_TPID);

   // builds the second descriptor word; only the last buffer gets full status
   always_comb begin
      word = 32'h00000000;
      word[rxbm_pkg::ST_SOF] = sof;
      if (sof && !jumbo) begin
         word[rxbm_pkg::ST_OFS_LO +: 2] = ofs;
      end
      if (eof) begin
         word[rxbm_pkg::ST_EOF] = 1'b1;
         word[rxbm_pkg::ST_BCAST] = fstat.bcast;
         word[rxbm_pkg::ST_MHASH] = fstat.mhash;
         word[rxbm_pkg::ST_UHASH] = fstat.uhash;
         word[rxbm_pkg::ST_EXT] = fstat.ext;
         word[rxbm_pkg::ST_SA_LO +: 4] = {fstat.sa_hit[0], fstat.sa_hit[1],
                                          fstat.sa_hit[2], fstat.sa_hit[3]};
         word[rxbm_pkg::ST_TYPE] = fstat.type_hit;
         word[rxbm_pkg::ST_VLAN] = vlan;
         word[rxbm_pkg::ST_PRIO] = vlan && (fstat.vlan_id == 12'h000);
         if (vlan) begin
            word[rxbm_pkg::ST_VPRI_LO +: 3] = fstat.vlan_pri;
            word[rxbm_pkg::ST_CFI] = fstat.cfi;
         end
         word[rxbm_pkg::ST_LEN_W-1:0] = len[11:0];
         if (jumbo) begin
            word[rxbm_pkg::ST_OFS_LO +: 2] = len[13:12];
         end
      end
   end
endmodule : rxbm_status_fmt
`default_nettype wire

/* core/rxbm_top.sv */
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - receive buffers hold 128 bytes each
// - buffer addresses come from descriptor list
// - first buffer start shifted by cfg offset
// - descriptor is address word plus status word
// - overflowed buffer status zero except sof/offset
// - used buffer gets address bit0 set
// - full buffer continues frame in next descriptor
// - full status only in last descriptor
// - address word bits 31:2 give buffer base
// - address word bit1 marks list end
// - write only into buffers with owner clear
// - status bits 31..28 address match flags
// - bits 26..23 specific match, 22 type
// - bit 21 flags vlan tagged frame
// - bit 20 flags priority-only tag
// - bits 19:17 priority, 16 cfi
// - bit 15 end of frame
// - bit 14 start of frame
// - bits 13:12 first buffer offset
// - jumbo mode puts length bits there
// - bits 11:0 frame length
// - wrap bit or 1024th entry restarts list
// - owned descriptor flags buffer not available
// - cfg bit 17 drops fcs, shorter length
// - error recovers only current buffer
module rxbm_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_valid,
   input wire rxbm_pkg::rxbm_beat_t rx_beat,
   input wire rxbm_pkg::rxbm_fstat_t rx_fstat,
   output logic rx_ready,
   output rxbm_pkg::rxbm_mreq_t mem_req,
   input wire logic mem_done,
   input wire logic [31:0] mem_rdata,
   output logic buf_unavail,
   output logic buf_unavail_evt
);
   typedef enum logic [2:0] {
      S_IDLE, S_FETCH, S_CHECK, S_FILL, S_WDATA, S_WSTAT, S_WOWN, S_DROP
   } rxbm_state_t;

   rxbm_state_t state_r, state_nxt;
   logic rxen_r, jumbo_r, nofcs_r, rcv_r, bna_r, bna_evt_r;
   logic [1:0] ofs_r;
   logic [29:0] qbase_r;
   logic [9:0] idx_r;
   logic [31:0] d0_r, word_r, word_ins, wbuf_r, waddr_r;
   logic [6:0] pos_r;
   logic [13:0] len_r;
   logic sof_r, eof_r, bufend_r, dirty_r;
   rxbm_pkg::rxbm_fstat_t fstat_r;
   rxbm_pkg::rxbm_mreq_t mreq_r;
   logic [31:0] prdata_r, status_word, desc_addr, buf_base;
   logic pready_r, pslverr_r, rx_ready_r;
   logic acc, store, flush, apb_wr, apb_setup, mapped, owned;

   assign acc = rx_valid && rx_ready_r;
   assign store = acc && !rx_beat.err && !(rx_beat.fcs && nofcs_r);
   assign flush = store && (pos_r[1:0] == 2'h3 || pos_r == rxbm_pkg::BUF_LAST_POS)
                  || acc && !rx_beat.err && rx_beat.last && (dirty_r || store);
   assign desc_addr = {qbase_r, 2'b00} + {19'h00000, idx_r, 3'b000};
   assign buf_base = {d0_r[31:2], 2'b00};
   assign owned = d0_r[rxbm_pkg::D0_OWN_BIT];
   assign apb_setup = psel && !penable;
   assign apb_wr = psel && penable && pready_r && pwrite;
   assign mapped = paddr == rxbm_pkg::REG_CTRL || paddr == rxbm_pkg::REG_CFG
                   || paddr == rxbm_pkg::REG_QPTR || paddr == rxbm_pkg::REG_STAT;

   // places the stored byte in its lane of the word being assembled
   for (genvar l = 0; l < 4; l++) begin : g_lane
      assign word_ins[8*l +: 8] = (store && pos_r[1:0] == 2'(l)) ? rx_beat.data
                                                                 : word_r[8*l +: 8];
   end

   rxbm_status_fmt u_fmt (
      .fstat(fstat_r),
      .sof(sof_r),
      .eof(eof_r),
      .ofs(ofs_r),
      .jumbo(jumbo_r),
      .len(len_r),
      .word(status_word)
   );

   // next state of the buffer walk
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         S_IDLE: begin
            if (rxen_r && rx_valid) begin
               state_nxt = S_FETCH;
            end
         end
         S_FETCH: begin
            if (mreq_r.valid && mem_done) begin
               state_nxt = S_CHECK;
            end
         end
         S_CHECK: begin
            state_nxt = owned ? S_DROP : S_FILL;
         end
         S_FILL: begin
            if (acc && rx_beat.err) begin
               state_nxt = rx_beat.last ? S_IDLE : S_DROP;
            end else if (flush) begin
               state_nxt = S_WDATA;
            end else if (acc && rx_beat.last) begin
               state_nxt = S_WSTAT;
            end
         end
         S_WDATA: begin
            if (mreq_r.valid && mem_done) begin
               state_nxt = (eof_r || bufend_r) ? S_WSTAT : S_FILL;
            end
         end
         S_WSTAT: begin
            if (mreq_r.valid && mem_done) begin
               state_nxt = S_WOWN;
            end
         end
         S_WOWN: begin
            if (mreq_r.valid && mem_done) begin
               state_nxt = eof_r ? S_IDLE : S_FETCH;
            end
         end
         S_DROP: begin
            if (acc && rx_beat.last) begin
               state_nxt = S_IDLE;
            end
         end
         default: state_nxt = S_IDLE;
      endcase
   end

   // state register and receive-side ready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= S_IDLE;
         rx_ready_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         rx_ready_r <= state_nxt == S_FILL || state_nxt == S_DROP;
      end
   end

   // buffer fill position, word assembly, frame length and markers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pos_r <= 7'h00;
         word_r <= 32'h00000000;
         wbuf_r <= 32'h00000000;
         waddr_r <= 32'h00000000;
         len_r <= 14'h0000;
         sof_r <= 1'b0;
         eof_r <= 1'b0;
         bufend_r <= 1'b0;
         dirty_r <= 1'b0;
         fstat_r <= '0;
      end else begin
         case (state_r)
            S_IDLE: begin
               len_r <= 14'h0000;
               sof_r <= 1'b1;
               eof_r <= 1'b0;
            end
            S_CHECK: begin
               pos_r <= sof_r ? {5'h00, ofs_r} : 7'h00;
               word_r <= 32'h00000000;
               dirty_r <= 1'b0;
               bufend_r <= 1'b0;
            end
            S_FILL: begin
               if (store) begin
                  pos_r <= pos_r + 7'h01;
                  len_r <= len_r + 14'h0001;
                  word_r <= word_ins;
                  dirty_r <= 1'b1;
               end
               if (acc && rx_beat.last) begin
                  eof_r <= 1'b1;
                  fstat_r <= rx_fstat;
               end
               if (flush) begin
                  wbuf_r <= word_ins;
                  waddr_r <= buf_base + {25'h0000000, pos_r[6:2], 2'b00};
                  bufend_r <= store && pos_r == rxbm_pkg::BUF_LAST_POS;
               end
            end
            S_WDATA: begin
               if (mreq_r.valid && mem_done) begin
                  word_r <= 32'h00000000;
                  dirty_r <= 1'b0;
               end
            end
            S_WOWN: begin
               if (mreq_r.valid && mem_done) begin
                  sof_r <= 1'b0;
               end
            end
            default: ;
         endcase
      end
   end

   // memory requests: issued in each memory state, dropped on completion
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mreq_r <= '0;
      end else if (mreq_r.valid) begin
         if (mem_done) begin
            mreq_r.valid <= 1'b0;
         end
      end else begin
         case (state_r)
            S_FETCH: mreq_r <= {1'b1, 1'b0, desc_addr, 32'h00000000};
            S_WDATA: mreq_r <= {1'b1, 1'b1, waddr_r, wbuf_r};
            S_WSTAT: mreq_r <= {1'b1, 1'b1, desc_addr + rxbm_pkg::DESC_STAT_OFS,
                                status_word};
            S_WOWN: begin
               mreq_r <= {1'b1, 1'b1, desc_addr, d0_r};
               mreq_r.wdata[rxbm_pkg::D0_OWN_BIT] <= 1'b1;
            end
            default: mreq_r <= '0;
         endcase
      end
   end

   // fetched address word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         d0_r <= 32'h00000000;
      end else if (state_r == S_FETCH && mreq_r.valid && mem_done) begin
         d0_r <= mem_rdata;
      end
   end

   // list base and descriptor index; a write of the pointer restarts the list
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         qbase_r <= 30'h00000000;
         idx_r <= 10'h000;
      end else if (apb_wr && paddr == rxbm_pkg::REG_QPTR) begin
         qbase_r <= pwdata[31:2];
         idx_r <= 10'h000;
      end else if (state_r == S_WOWN && mreq_r.valid && mem_done) begin
         if (d0_r[rxbm_pkg::D0_WRAP_BIT] || idx_r == rxbm_pkg::DESC_LAST_IDX) begin
            idx_r <= 10'h000;
         end else begin
            idx_r <= idx_r + 10'h001;
         end
      end
   end

   // control and configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxen_r <= 1'b0;
         jumbo_r <= 1'b0;
         nofcs_r <= 1'b0;
         ofs_r <= 2'h0;
      end else if (apb_wr && paddr == rxbm_pkg::REG_CTRL) begin
         rxen_r <= pwdata[rxbm_pkg::CTRL_RXEN_BIT];
      end else if (apb_wr && paddr == rxbm_pkg::REG_CFG) begin
         jumbo_r <= pwdata[rxbm_pkg::CFG_JUMBO_BIT];
         nofcs_r <= pwdata[rxbm_pkg::CFG_NOFCS_BIT];
         ofs_r <= pwdata[rxbm_pkg::CFG_OFS_LO +: 2];
      end
   end

   // sticky status; hardware set wins over a write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bna_r <= 1'b0;
         rcv_r <= 1'b0;
         bna_evt_r <= 1'b0;
      end else begin
         bna_evt_r <= state_r == S_CHECK && owned;
         if (state_r == S_CHECK && owned) begin
            bna_r <= 1'b1;
         end else if (apb_wr && paddr == rxbm_pkg::REG_STAT
                      && pwdata[rxbm_pkg::STAT_BNA_BIT]) begin
            bna_r <= 1'b0;
         end
         if (state_r == S_FILL && acc && rx_beat.err) begin
            rcv_r <= 1'b1;
         end else if (apb_wr && paddr == rxbm_pkg::REG_STAT
                      && pwdata[rxbm_pkg::STAT_RCV_BIT]) begin
            rcv_r <= 1'b0;
         end
      end
   end

   // apb slave: ready in the first access cycle, data latched at setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h00000000;
      end else begin
         pready_r <= apb_setup;
         pslverr_r <= apb_setup && !mapped;
         if (apb_setup) begin
            prdata_r <= 32'h00000000;
            case (paddr)
               rxbm_pkg::REG_CTRL: prdata_r[rxbm_pkg::CTRL_RXEN_BIT] <= rxen_r;
               rxbm_pkg::REG_CFG: begin
                  prdata_r[rxbm_pkg::CFG_JUMBO_BIT] <= jumbo_r;
                  prdata_r[rxbm_pkg::CFG_NOFCS_BIT] <= nofcs_r;
                  prdata_r[rxbm_pkg::CFG_OFS_LO +: 2] <= ofs_r;
               end
               rxbm_pkg::REG_QPTR: prdata_r <= desc_addr;
               rxbm_pkg::REG_STAT: begin
                  prdata_r[rxbm_pkg::STAT_BNA_BIT] <= bna_r;
                  prdata_r[rxbm_pkg::STAT_RCV_BIT] <= rcv_r;
               end
               default: prdata_r <= 32'h00000000;
            endcase
         end
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign rx_ready = rx_ready_r;
   assign mem_req = mreq_r;
   assign buf_unavail = bna_r;
   assign buf_unavail_evt = bna_evt_r;

   // checks on the buffer walk
   property p_bufcap;
      @(posedge pclk) disable iff (!presetn)
      (state_r == S_FILL && store && pos_r == rxbm_pkg::BUF_LAST_POS) |=> state_r == S_WDATA;
   endproperty
   a_bufcap: assert property (p_bufcap) else $error("full buffer not flushed");

   property p_fetch_addr;
      @(posedge pclk) disable iff (!presetn)
      (mreq_r.valid && state_r == S_FETCH) |-> !mreq_r.write && mreq_r.addr == desc_addr;
   endproperty
   a_fetch_addr: assert property (p_fetch_addr) else $error("bad fetch address");

   property p_first_ofs;
      @(posedge pclk) disable iff (!presetn)
      (state_r == S_CHECK && !owned && sof_r) |=> pos_r == {5'h00, ofs_r};
   endproperty
   a_first_ofs: assert property (p_first_ofs) else $error("first buffer offset wrong");

   property p_stat_addr;
      @(posedge pclk) disable iff (!presetn)
      (mreq_r.valid && state_r == S_WSTAT) |-> mreq_r.addr == desc_addr + 32'h00000004;
   endproperty
   a_stat_addr: assert property (p_stat_addr) else $error("status word misplaced");

   property p_own_set;
      @(posedge pclk) disable iff (!presetn)
      (mreq_r.valid && state_r == S_WOWN) |-> mreq_r.wdata[0] && mreq_r.addr == desc_addr;
   endproperty
   a_own_set: assert property (p_own_set) else $error("owner bit not written");

   property p_no_write_owned;
      @(posedge pclk) disable iff (!presetn)
      (state_r == S_CHECK && owned) |=> state_r == S_DROP ##1 !(mreq_r.valid && mreq_r.write);
   endproperty
   a_no_write_owned: assert property (p_no_write_owned) else $error("owned buffer used");

   property p_bna;
      @(posedge pclk) disable iff (!presetn)
      (state_r == S_CHECK && owned) |=> bna_r && buf_unavail_evt ##1 !buf_unavail_evt;
   endproperty
   a_bna: assert property (p_bna) else $error("buffer not available missed");

   property p_wrap;
      @(posedge pclk) disable iff (!presetn)
      (state_r == S_WOWN && mreq_r.valid && mem_done && d0_r[1]
       && !(apb_wr && paddr == rxbm_pkg::REG_QPTR)) |=> idx_r == 10'h000;
   endproperty
   a_wrap: assert property (p_wrap) else $error("list did not wrap");

   property p_nofcs;
      @(posedge pclk) disable iff (!presetn)
      (state_r == S_FILL && acc && rx_beat.fcs && nofcs_r) |=> $stable(len_r);
   endproperty
   a_nofcs: assert property (p_nofcs) else $error("dropped fcs counted");

   property p_mid_status;
      @(posedge pclk) disable iff (!presetn)
      (mreq_r.valid && state_r == S_WSTAT && !eof_r) |-> mreq_r.wdata[31:15] == 17'h00000
                                                          && mreq_r.wdata[11:0] == 12'h000;
   endproperty
   a_mid_status: assert property (p_mid_status) else $error("overflow status not clear");
endmodule : rxbm_top
`default_nettype wire

/* verification/rxbm_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rxbm_mem_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic slow,
   input wire rxbm_pkg::rxbm_mreq_t mem_req,
   output logic mem_done,
   output logic [31:0] mem_rdata
);
   // 2 kbyte of word memory: descriptor list and receive buffers
   logic [31:0] mem [0:511];
   logic [2:0] wait_r;

   // one done pulse per word request, optionally after a stall
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_done <= 1'b0;
         wait_r <= 3'h0;
         mem_rdata <= 32'h0;
      end else if (!mem_done && mem_req.valid && wait_r == 3'h0) begin
         mem_done <= 1'b1;
         wait_r <= slow ? 3'h3 : 3'h0;
         // descriptor word pairs live here like any other word
         if (mem_req.write) mem[mem_req.addr[10:2]] <= mem_req.wdata;
         else mem_rdata <= mem[mem_req.addr[10:2]];
      end else begin
         mem_done <= 1'b0;
         mem_rdata <= ~mem_rdata; // read data is not held past its pulse
         if (mem_req.valid && wait_r != 3'h0) wait_r <= wait_r - 3'h1;
      end
   end
endmodule : rxbm_mem_model
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [31:0] LIST = 32'h00000040;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, mem_rdata, q;
   logic pready, pslverr, rx_ready, mem_done, buf_unavail, buf_unavail_evt, e;
   logic rx_valid = 1'b0;
   logic slow = 1'b0;
   rxbm_pkg::rxbm_beat_t rx_beat = '0;
   rxbm_pkg::rxbm_fstat_t rx_fstat = '0;
   rxbm_pkg::rxbm_mreq_t mem_req;
   logic [31:0] seed = 32'h149C69FF;
   logic [7:0] fr [0:255];
   int err_count = 0;
   int comparisons = 0;
   int cycles = 0;
   int cur = 0;
   int evt_count = 0;

   rxbm_top i_rxbm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_valid(rx_valid), .rx_beat(rx_beat), .rx_fstat(rx_fstat),
      .rx_ready(rx_ready), .mem_req(mem_req), .mem_done(mem_done), .mem_rdata(mem_rdata),
      .buf_unavail(buf_unavail), .buf_unavail_evt(buf_unavail_evt));
   rxbm_mem_model i_rxbm_mem_model (.pclk(pclk), .presetn(presetn), .slow(slow),
      .mem_req(mem_req), .mem_done(mem_done), .mem_rdata(mem_rdata));

   // clock, hang guard and event counter
   always #5 pclk = ~pclk;
   always @(posedge pclk) begin
      cycles++;
      if (buf_unavail_evt === 1'b1) evt_count++;
      if (cycles == 40000) begin
         err_count++;
         finish_test();
      end
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   // expected status word of one used buffer
   function automatic logic [31:0] exp_st(rxbm_pkg::rxbm_fstat_t f, logic sof, logic eof,
                                          logic [1:0] o, logic j, logic [13:0] n);
      logic [31:0] s;
      s = 32'h0;
      s[14] = sof;
      if (sof && !j) s[13:12] = o;
      if (eof) begin
         s[31:28] = {f.bcast, f.mhash, f.uhash, f.ext};
         s[26:23] = {f.sa_hit[0], f.sa_hit[1], f.sa_hit[2], f.sa_hit[3]};
         s[22] = f.type_hit;
         s[21] = f.type_id == 16'h8100;
         s[20] = s[21] && f.vlan_id == 12'h000;
         if (s[21]) s[19:16] = {f.vlan_pri, f.cfi};
         s[15] = 1'b1;
         s[11:0] = n[11:0];
         if (j) s[13:12] = n[13:12];
      end
      return s;
   endfunction : exp_st

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one apb transfer: setup, then access until pready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // one frame of n bytes (last four are fcs), then its memory image is checked, or the status register for an owned frame and descriptors too for a bad one
   task automatic run_frame(input int n, input logic nf, input logic [1:0] o, input logic j,
                            input logic own, input logic bad);
      int st, cap, nb, d, ev, k, b;
      logic [31:0] r, s, m;
      rxbm_pkg::rxbm_fstat_t f;
      for (k = 0; k < 4; k++) begin // software hands all four buffers back
         i_rxbm_mem_model.mem[16 + 2 * k] = 32'(256 + 128 * k + (k == 3 ? 2 : 0));
      end
      if (own) i_rxbm_mem_model.mem[16 + 2 * cur][0] = 1'b1;
      apb(1'b1, rxbm_pkg::REG_CFG, {14'h0, nf, 1'b0, o, 10'h0, j, 3'h0}, r, e);
      r = rnd();
      f = {r, r[8:0]};
      if (r[3]) f.type_id = 16'h8100;
      if (r[5]) f.vlan_id = 12'h000;
      for (k = 0; k < n; k++) fr[k] = 8'(rnd());
      ev = evt_count;
      rx_fstat <= f;
      rx_valid <= 1'b1;
      rx_beat <= '{fr[0], 1'b0, 1'b0, 1'b0};
      k = 0;
      while (k < n) begin
         @(posedge pclk);
         if (rx_ready === 1'b1) begin
            k++;
            if (k == n) rx_valid <= 1'b0;
            else rx_beat <= '{fr[k], k == n - 1, bad && k == n - 1, k >= n - 4};
         end
      end
      st = nf ? n - 4 : n;
      cap = 128 - o;
      // a full first buffer moves on even when only dropped fcs bytes follow
      nb = (st > cap || nf && st == cap) ? 2 : 1;
      if (own) begin
         for (k = 0; k < 300 && buf_unavail !== 1'b1; k++) @(posedge pclk);
         chk({31'h0, buf_unavail}, 32'h1);
         chk(32'(evt_count - ev), 32'h1);
         apb(1'b0, rxbm_pkg::REG_STAT, 32'h0, r, e);
         chk(r & 32'h1, 32'h1);
         apb(1'b1, rxbm_pkg::REG_STAT, 32'h1, r, e);
         apb(1'b0, rxbm_pkg::REG_STAT, 32'h0, r, e);
         chk(r & 32'h1, 32'h0);
         apb(1'b1, rxbm_pkg::REG_QPTR, LIST, r, e);
         cur = 0;
         return;
      end
      // error on the last byte: only the buffer being written is recovered
      if (bad) begin
         d = (nf ? n - 4 : n - 1) >= cap;
         repeat (4) @(posedge pclk);
         chk(i_rxbm_mem_model.mem[16 + 2 * cur] & 32'h1, 32'(d));
         chk(i_rxbm_mem_model.mem[16 + 2 * ((cur + 1) % 4)] & 32'h1, 32'h0);
         cur = (cur + d) % 4;
         apb(1'b0, rxbm_pkg::REG_STAT, 32'h0, r, e);
         chk(r & 32'h2, 32'h2);
         apb(1'b1, rxbm_pkg::REG_STAT, 32'h2, r, e);
         apb(1'b0, rxbm_pkg::REG_QPTR, 32'h0, r, e);
         chk(r, LIST + 32'(8 * cur));
         return;
      end
      d = (cur + nb - 1) % 4;
      for (k = 0; k < 400 && i_rxbm_mem_model.mem[16 + 2 * d][0] !== 1'b1; k++) @(posedge pclk);
      repeat (2) @(posedge pclk);
      for (b = 0; b < nb; b++) begin
         d = (cur + b) % 4;
         m = 32'(256 + 128 * d + (d == 3 ? 3 : 1)); // owner bit set, wrap bit kept
         chk(i_rxbm_mem_model.mem[16 + 2 * d], m);
         s = exp_st(f, b == 0, b == nb - 1, o, j, 14'(st));
         m = (s[15] && !s[21]) ? 32'hFFF0FFFF : 32'hFFFFFFFF;
         chk(i_rxbm_mem_model.mem[17 + 2 * d] & m, s & m);
      end
      for (k = 0; k < st; k++) begin
         d = (k < cap) ? cur : (cur + 1) % 4;
         b = (k < cap) ? 256 + 128 * d + o + k : 256 + 128 * d + k - cap; // byte address
         r = i_rxbm_mem_model.mem[b / 4];
         chk(32'(r[8 * (b % 4) +: 8]), 32'(fr[k]));
      end
      cur = (cur + nb) % 4; // the wrap entry sends the list back to its start
      apb(1'b0, rxbm_pkg::REG_QPTR, 32'h0, r, e);
      chk(r, LIST + 32'(8 * cur));
   endtask : run_frame

   task automatic finish_test();
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : finish_test

   // register checks, corner frames, then random frames with one owned descriptor
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, rxbm_pkg::REG_CFG, 32'h0, q, e);
      chk(q, 32'h0);
      apb(1'b0, 8'h10, 32'h0, q, e);
      chk({31'h0, e}, 32'h1);
      chk(q, 32'h0);
      apb(1'b1, rxbm_pkg::REG_CFG, 32'hFFFFFFFF, q, e);
      apb(1'b0, rxbm_pkg::REG_CFG, 32'h0, q, e);
      chk(q, rxbm_pkg::CFG_MASK);
      apb(1'b1, rxbm_pkg::REG_QPTR, LIST, q, e);
      apb(1'b1, rxbm_pkg::REG_CTRL, 32'h1, q, e);
      run_frame(125, 1'b0, 2'h3, 1'b0, 1'b0, 1'b0);
      run_frame(130, 1'b1, 2'h1, 1'b0, 1'b0, 1'b0);
      run_frame(129, 1'b0, 2'h0, 1'b1, 1'b0, 1'b0);
      for (int i = 0; i < 12; i++) begin
         q = rnd();
         slow <= q[9];
         run_frame(8 + int'(q[7:0] % 190), q[8], q[11:10], q[12], i == 6, i == 9);
      end
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
